/* tba_pkg.sv */
package tba_pkg;

  // ----------------------------------------------------------------------
  // Sizes and clocking
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TIMER_W = 20;
  localparam int FADE_W = 18;
  localparam int WIN_W = 8;

  // ----------------------------------------------------------------------
  // Timing (figure in its own unit, then cycles, except POR_MAX_MS)
  // ----------------------------------------------------------------------
  localparam int POR_MAX_MS = 150;
  localparam int BOOT_TIME_US = 2000;
  localparam int BOOT_CYC = BOOT_TIME_US * CYC_PER_US;
  localparam int SCAN_PERIOD_MS = 30;
  localparam int SCAN_CYC = SCAN_PERIOD_MS * CYC_PER_MS;
  localparam int SENSE_TIME_US = 10;
  localparam int SENSE_CYC = SENSE_TIME_US * CYC_PER_US;
  localparam int FADE_STEP_MS = 8;
  localparam int FADE_CYC = FADE_STEP_MS * CYC_PER_MS;

  // ----------------------------------------------------------------------
  // Detection, lighting and link values
  // ----------------------------------------------------------------------
  localparam logic [7:0] TOUCH_THR = 8'h64;
  localparam logic [7:0] TOUCH_HYS = 8'h08;
  localparam logic [7:0] TOUCH_ON_LVL = TOUCH_THR + TOUCH_HYS;
  localparam logic [7:0] TOUCH_OFF_LVL = TOUCH_THR - TOUCH_HYS;
  localparam logic [7:0] TICK_MAX = 8'hFF;
  localparam logic [7:0] LED_FULL = 8'hFF;
  localparam logic [7:0] LED_OFF = 8'h00;
  // Arbitrary default slave address
  localparam logic [6:0] I2C_ADDR_DEF = 7'h2B;
  localparam int CMD_SLEEP_BIT = 0;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [7:0] tba_tick_t;
  typedef tba_tick_t [NUM_CH-1:0] tba_tick_vec_t;

  typedef struct packed {
    logic [NUM_CH-1:0] o;
    logic [NUM_CH-1:0] oe;
  } tba_pin_drv_t;

  typedef struct packed {
    logic o;
    logic oe;
  } tba_od_drv_t;

  typedef enum logic [2:0] {
    SCAN_BOOT,
    SCAN_SENSE,
    SCAN_PROC,
    SCAN_WAIT,
    SCAN_SLEEP
  } tba_scan_t;

  typedef enum logic [3:0] {
    LNK_IDLE,
    LNK_ADDR,
    LNK_ACKW,
    LNK_ACKH,
    LNK_WR,
    LNK_LOAD,
    LNK_RD,
    LNK_RACK,
    LNK_RWAIT
  } tba_link_t;

endpackage

/* tba_charge_count.sv */
module tba_charge_count
  import tba_pkg::*;
#(
  parameter int SENSE_CYCLES = SENSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sense_start,
  input wire logic [NUM_CH-1:0] cmp_in,
  output tba_tick_vec_t ticks,
  output logic sense_done
);

  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(SENSE_CYCLES - 1);

  typedef struct packed {
    logic [NUM_CH-1:0] cmp_s1;
    logic [NUM_CH-1:0] cmp_s2;
    logic busy;
    logic [WIN_W-1:0] win;
    tba_tick_vec_t acc;
    tba_tick_vec_t ticks;
    logic done;
  } tba_cc_st_t;

  tba_cc_st_t st_reg;
  tba_cc_st_t st_next;

  // ----------------------------------------------------------------------
  // Window counting
  // ----------------------------------------------------------------------
  // Comparator stays high while charge integrates, so a larger charge
  // gives a longer high time and more ticks; saturates, never wraps.
  always_comb begin
    st_next = st_reg;
    st_next.cmp_s1 = cmp_in;
    st_next.cmp_s2 = st_reg.cmp_s1;
    st_next.done = 1'b0;
    if (sense_start && !st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.win = '0;
      st_next.acc = '0;
    end else if (st_reg.busy) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (st_reg.cmp_s2[i] && st_reg.acc[i] != TICK_MAX) begin
          st_next.acc[i] = st_reg.acc[i] + 8'h01;
        end
      end
      if (st_reg.win == WIN_LAST) begin
        st_next.busy = 1'b0;
        st_next.ticks = st_next.acc;
        st_next.done = 1'b1;
      end else begin
        st_next.win = st_reg.win + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ticks = st_reg.ticks;
  assign sense_done = st_reg.done;

endmodule

/* tba_log_fader.sv */
module tba_log_fader
  import tba_pkg::*;
#(
  parameter int FADE_CYCLES = FADE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_CH-1:0] touched,
  output logic [NUM_CH-1:0] pwm
);

  localparam logic [FADE_W-1:0] STEP_LAST = FADE_W'(FADE_CYCLES - 1);

  typedef struct packed {
    logic [7:0] pwm_cnt;
    logic [FADE_W-1:0] step;
    tba_tick_vec_t level;
    logic [NUM_CH-1:0] pwm;
  } tba_fd_st_t;

  tba_fd_st_t st_reg;
  tba_fd_st_t st_next;
  logic step_tick;

  // Each step removes an eighth plus one: geometric decay, so the
  // perceived brightness falls along a logarithmic curve.
  function automatic logic [7:0] fade_next(input logic [7:0] lvl);
    fade_next = 8'(lvl - ((lvl >> 3) + 8'h01));
  endfunction

  // ----------------------------------------------------------------------
  // Level and PWM
  // ----------------------------------------------------------------------
  assign step_tick = (st_reg.step == STEP_LAST);

  always_comb begin
    st_next = st_reg;
    st_next.pwm_cnt = st_reg.pwm_cnt + 8'h01;
    st_next.step = step_tick ? '0 : st_reg.step + 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (touched[i]) begin
        st_next.level[i] = LED_FULL;
      end else if (step_tick && st_reg.level[i] != LED_OFF) begin
        st_next.level[i] = fade_next(st_reg.level[i]);
      end
      st_next.pwm[i] = (st_reg.level[i] > st_reg.pwm_cnt);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm = st_reg.pwm;

endmodule

/* tba_touch_core.sv */
module tba_touch_core
  import tba_pkg::*;
#(
  parameter int BOOT_CYCLES = BOOT_CYC,
  parameter int SCAN_CYCLES = SCAN_CYC,
  parameter int FADE_CYCLES = FADE_CYC,
  parameter logic [6:0] I2C_ADDR = I2C_ADDR_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_scl,
  input wire logic scl_in,
  input wire logic sda_in,
  output tba_od_drv_t sda_drv,
  input wire logic reset_n_pin,
  input wire logic [NUM_CH-1:0] sensor_input,
  input wire logic [NUM_CH-1:0] led_pin_in,
  output tba_pin_drv_t led_pin_drv,
  input wire logic irq_n_pin_in,
  output tba_od_drv_t irq_n_pin_drv
);

  localparam logic [TIMER_W-1:0] BOOT_LAST = TIMER_W'(BOOT_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SCAN_LAST = TIMER_W'(SCAN_CYCLES - 1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rstn_sync;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [1:0][NUM_CH-1:0] gpi_sync;
    tba_scan_t scan;
    logic [TIMER_W-1:0] timer;
    logic sense_start;
    logic [NUM_CH-1:0] touched;
    logic irq_pend;
    logic irq_oe;
    logic [NUM_CH-1:0] led_oe;
    tba_link_t link;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic byte_sel;
    logic [7:0] cmd;
    logic sda_oe;
  } tba_core_st_t;

  tba_core_st_t st_reg;
  tba_core_st_t st_next;

  logic core_rst;
  logic link_bit;
  logic sense_done;
  tba_tick_vec_t ticks;
  logic [NUM_CH-1:0] pwm;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sleep_req;

  // Two states only, with hysteresis so transients do not chatter
  function automatic logic touch_next(input logic cur, input tba_tick_t t);
    if (t >= TOUCH_ON_LVL) begin
      touch_next = 1'b1;
    end else if (t < TOUCH_OFF_LVL) begin
      touch_next = 1'b0;
    end else begin
      touch_next = cur;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------------
  // Data bit caught on the master's own rising edge; held until the next
  // rise, which is far longer than the system side needs to read it.
  always_ff @(posedge clk_scl) begin
    if (rst) begin
      link_bit <= 1'b1;
    end else begin
      link_bit <= sda_in;
    end
  end

  // ----------------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------------
  // The reset pin and the core reset both restart everything past the
  // synchronisers; the pin is only looked at after two flops.
  assign core_rst = rst | ~st_reg.rstn_sync[1];
  assign scl_rise = ~st_reg.scl_prev & st_reg.scl_sync[1];
  assign scl_fall = st_reg.scl_prev & ~st_reg.scl_sync[1];
  assign bus_start = st_reg.scl_prev & st_reg.scl_sync[1] & st_reg.sda_prev
    & ~st_reg.sda_sync[1];
  assign bus_stop = st_reg.scl_prev & st_reg.scl_sync[1] & ~st_reg.sda_prev
    & st_reg.sda_sync[1];
  assign sleep_req = st_reg.cmd[CMD_SLEEP_BIT];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rstn_sync = {st_reg.rstn_sync[0], reset_n_pin};
    st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
    st_next.scl_prev = st_reg.scl_sync[1];
    st_next.sda_prev = st_reg.sda_sync[1];
    st_next.gpi_sync = {st_reg.gpi_sync[0], led_pin_in};
    st_next.sense_start = 1'b0;

    // Link first, so a button event in the same cycle beats the clear
    if (bus_start) begin
      st_next.link = LNK_ADDR;
      st_next.bit_cnt = '0;
      st_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      st_next.link = LNK_IDLE;
      st_next.sda_oe = 1'b0;
    end else begin
      case (st_reg.link)
        LNK_IDLE: begin
          st_next.sda_oe = 1'b0;
        end
        LNK_ADDR: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], link_bit};
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            if (st_reg.bit_cnt == BIT_LAST) begin
              if (st_reg.shift[6:0] == I2C_ADDR) begin
                st_next.rw = link_bit;
                st_next.byte_sel = 1'b0;
                st_next.link = LNK_ACKW;
              end else begin
                st_next.link = LNK_IDLE;
              end
            end
          end
        end
        LNK_ACKW: begin
          if (scl_fall) begin
            st_next.sda_oe = 1'b1;
            st_next.link = LNK_ACKH;
          end
        end
        LNK_ACKH: begin
          if (scl_fall) begin
            st_next.sda_oe = 1'b0;
            st_next.bit_cnt = '0;
            st_next.link = st_reg.rw ? LNK_LOAD : LNK_WR;
          end
        end
        LNK_WR: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], link_bit};
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            if (st_reg.bit_cnt == BIT_LAST) begin
              st_next.cmd = {st_reg.shift[6:0], link_bit};
              st_next.link = LNK_ACKW;
            end
          end
        end
        LNK_LOAD: begin
          // Byte 0 is the button snapshot, byte 1 the general inputs
          if (st_reg.byte_sel) begin
            st_next.shift = {st_reg.gpi_sync[1][6:0], 1'b0};
            st_next.sda_oe = ~st_reg.gpi_sync[1][7];
          end else begin
            st_next.shift = {st_reg.touched[6:0], 1'b0};
            st_next.sda_oe = ~st_reg.touched[7];
            st_next.irq_pend = 1'b0;
          end
          st_next.byte_sel = ~st_reg.byte_sel;
          st_next.bit_cnt = 3'h1;
          st_next.link = LNK_RD;
        end
        LNK_RD: begin
          if (scl_fall) begin
            if (st_reg.bit_cnt == 3'h0) begin
              st_next.sda_oe = 1'b0;
              st_next.link = LNK_RACK;
            end else begin
              st_next.sda_oe = ~st_reg.shift[7];
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            end
          end
        end
        LNK_RACK: begin
          if (scl_rise) begin
            st_next.link = link_bit ? LNK_IDLE : LNK_RWAIT;
          end
        end
        LNK_RWAIT: begin
          if (scl_fall) begin
            st_next.link = LNK_LOAD;
          end
        end
        default: begin
          st_next.link = LNK_IDLE;
          st_next.sda_oe = 1'b0;
        end
      endcase
    end

    // Scan sequencing runs on its own; the link only has to restart it after sleep
    case (st_reg.scan)
      SCAN_BOOT: begin
        if (st_reg.timer == BOOT_LAST) begin
          st_next.scan = SCAN_SENSE;
          st_next.timer = '0;
          st_next.sense_start = 1'b1;
        end else begin
          st_next.timer = st_reg.timer + 1'b1;
        end
      end
      SCAN_SENSE: begin
        st_next.timer = st_reg.timer + 1'b1;
        if (sense_done) begin
          st_next.scan = SCAN_PROC;
        end
      end
      SCAN_PROC: begin
        st_next.timer = st_reg.timer + 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
          st_next.touched[i] = touch_next(st_reg.touched[i], ticks[i]);
          if (st_next.touched[i] != st_reg.touched[i]) begin
            st_next.irq_pend = 1'b1;
          end
        end
        st_next.scan = SCAN_WAIT;
      end
      SCAN_WAIT: begin
        // Sleep takes effect only at a period boundary
        if (st_reg.timer >= SCAN_LAST) begin
          st_next.timer = '0;
          if (sleep_req) begin
            st_next.scan = SCAN_SLEEP;
          end else begin
            st_next.scan = SCAN_SENSE;
            st_next.sense_start = 1'b1;
          end
        end else begin
          st_next.timer = st_reg.timer + 1'b1;
        end
      end
      SCAN_SLEEP: begin
        if (!sleep_req) begin
          st_next.scan = SCAN_SENSE;
          st_next.timer = '0;
          st_next.sense_start = 1'b1;
        end
      end
      default: begin
        st_next.scan = SCAN_BOOT;
        st_next.timer = '0;
      end
    endcase

    // Line held low through start-up, then only while news waits
    st_next.irq_oe = st_next.irq_pend | (st_next.scan == SCAN_BOOT);
    // In sleep the LED pins fall back to general input mode
    st_next.led_oe = (st_next.scan == SCAN_SLEEP) ? '0 : '1;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Synchronisers clear on rst only, so the pin reset
  // itself is released cleanly through them.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.scl_sync <= 2'h3;
      st_reg.sda_sync <= 2'h3;
      st_reg.scl_prev <= 1'b1;
      st_reg.sda_prev <= 1'b1;
      st_reg.irq_oe <= 1'b1;
      st_reg.led_oe <= '1;
      st_reg.scan <= SCAN_BOOT;
      st_reg.link <= LNK_IDLE;
      st_reg.cmd <= CMD_RST;
    end else if (core_rst) begin
      st_reg <= st_next;
      st_reg.scan <= SCAN_BOOT;
      st_reg.timer <= '0;
      st_reg.sense_start <= 1'b0;
      st_reg.touched <= '0;
      st_reg.irq_pend <= 1'b0;
      st_reg.irq_oe <= 1'b1;
      st_reg.led_oe <= '1;
      st_reg.link <= LNK_IDLE;
      st_reg.sda_oe <= 1'b0;
      st_reg.cmd <= CMD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Front end and LED drive
  // ----------------------------------------------------------------------
  tba_charge_count #(
    .SENSE_CYCLES(SENSE_CYC)
  ) u_charge_to_count_front_end (
    .clk_sys(clk_sys),
    .rst(core_rst),
    .sense_start(st_reg.sense_start),
    .cmp_in(sensor_input),
    .ticks(ticks),
    .sense_done(sense_done)
  );

  tba_log_fader #(
    .FADE_CYCLES(FADE_CYCLES)
  ) u_fader (
    .clk_sys(clk_sys),
    .rst(core_rst),
    .touched(st_reg.touched),
    .pwm(pwm)
  );

  assign led_pin_drv.o = pwm;
  assign led_pin_drv.oe = st_reg.led_oe;
  // Open drain: only ever pulls low
  assign sda_drv.o = 1'b0;
  assign sda_drv.oe = st_reg.sda_oe;
  assign irq_n_pin_drv.o = 1'b0;
  assign irq_n_pin_drv.oe = st_reg.irq_oe;

endmodule

/* tba_touch_core_sva.sv */
// ----------------------------------------
// Port checker
// ----------------------------------------
module tba_touch_core_sva
  import tba_pkg::*;
#(
  parameter int BOOT_CYCLES = BOOT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_scl,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire tba_od_drv_t sda_drv,
  input wire logic reset_n_pin,
  input wire logic [NUM_CH-1:0] sensor_input,
  input wire logic [NUM_CH-1:0] led_pin_in,
  input wire tba_pin_drv_t led_pin_drv,
  input wire logic irq_n_pin_in,
  input wire tba_od_drv_t irq_n_pin_drv
);
  logic boot_reg;
  logic [31:0] boot_cnt_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Boot is far too long for a repetition, so it is counted
  always_ff @(posedge clk_sys) begin
    if (rst || !reset_n_pin) begin
      boot_reg <= 1'b1;
      boot_cnt_reg <= '0;
    end else if (!irq_n_pin_drv.oe) begin
      boot_reg <= 1'b0;
    end else if (boot_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 32'h0000_0001;
    end
  end

  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_sda_free;
    !sda_drv.oe;
  endsequence

  a_irq_reset: assert property (disable iff (1'b0) rst |=> irq_n_pin_drv.oe)
    else $error("interrupt not asserted after reset");
  a_led_reset: assert property (disable iff (1'b0)
    rst |=> led_pin_drv.oe == 8'hFF && led_pin_drv.o == 8'h00)
    else $error("led pins not in reset state");
  a_irq_open_drain: assert property (irq_n_pin_drv.o == 1'b0)
    else $error("interrupt pin drives high");
  a_sda_open_drain: assert property (sda_drv.o == 1'b0)
    else $error("data line driven high");
  a_boot_bound: assert property (boot_reg |-> boot_cnt_reg <= BOOT_CYCLES + 8)
    else $error("interrupt line not released after boot");
  a_irq_fall_cause: assert property (
    $fell(irq_n_pin_drv.oe) |-> boot_reg || !scl_in)
    else $error("interrupt released without boot end or read");
  a_sda_steady_high: assert property (
    reset_n_pin && scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_drv.oe))
    else $error("data line changed while clock high");
  a_sda_pull_low: assert property (
    $rose(sda_drv.oe) |-> !scl_in && !$past(scl_in))
    else $error("data line pulled while clock high");
  a_start_release: assert property (s_start |-> ##[1:8] s_sda_free)
    else $error("data line held after start");
  a_led_dir_whole: assert property (
    led_pin_drv.oe == 8'hFF || led_pin_drv.oe == 8'h00)
    else $error("led pin directions split");
endmodule

bind tba_touch_core tba_touch_core_sva #(
  .BOOT_CYCLES(BOOT_CYCLES)
) u_sva (
  .clk_sys(clk_sys), .rst(rst), .clk_scl(clk_scl), .scl_in(scl_in), .sda_in(sda_in),
  .sda_drv(sda_drv), .reset_n_pin(reset_n_pin), .sensor_input(sensor_input),
  .led_pin_in(led_pin_in), .led_pin_drv(led_pin_drv), .irq_n_pin_in(irq_n_pin_in),
  .irq_n_pin_drv(irq_n_pin_drv)
);

/* tba_host_model.sv */
// ----------------------------------------
// Link master
// ----------------------------------------
module tba_host_model #(
  parameter time FREE_TIME = 500us
) (
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic addr_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  // 25 link ticks of 15 ns; both clock phases stay above 12 system cycles
  localparam time QTR = 375ns;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
    addr_ack = 1'b0;
  end

  task automatic put_bit(input logic b);
    sda_pull = !b;
    #QTR scl = 1'b1;
    #(2*QTR) scl = 1'b0;
    #QTR;
  endtask

  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR b = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic xfer(input logic [6:0] adr, input logic rd, input logic [7:0] wd);
    logic b;
    logic [7:0] v;
    v = {adr, rd};
    // Off the system clock grid, so link edges never meet its edges
    #7ns;
    sda_pull = 1'b1;
    #(2*QTR) scl = 1'b0;
    #QTR;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(b);
    addr_ack = !b;
    if (!b && rd) begin
      for (int k = 0; k < 2; k++) begin
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        rd_byte = v;
        rd_valid = 1'b1;
        // Last byte refused so the slave lets go of the line
        put_bit(k == 1);
        rd_valid = 1'b0;
      end
    end else if (!b) begin
      for (int i = 7; i >= 0; i--) put_bit(wd[i]);
      get_bit(b);
    end
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #(2*QTR) sda_pull = 1'b0;
    #FREE_TIME;
  endtask
endmodule

/* tb.sv */
module tb
  import tba_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reset_n_pin = 1'b1;
  logic [NUM_CH-1:0] sensor_input = '0;
  logic [NUM_CH-1:0] gpi_val = '0;
  logic scl;
  logic sda_pull;
  logic rd_valid;
  logic [7:0] rd_byte;
  logic addr_ack;
  logic sda;
  logic irq_line;
  logic [NUM_CH-1:0] led_pins;
  tba_od_drv_t sda_drv;
  tba_od_drv_t irq_drv;
  tba_pin_drv_t led_drv;
  logic [8:0] exp_q[$];
  logic [8:0] nxt;
  logic [31:0] seed = 32'h0001_49FF;
  int num_errors = 0;
  int checks_done = 0;

  // Open-drain lines rest high through their pull-ups
  assign sda = !(sda_drv.oe || sda_pull);
  assign irq_line = !irq_drv.oe;
  assign led_pins = (led_drv.oe & led_drv.o) | (~led_drv.oe & gpi_val);
  always #25 clk_sys = !clk_sys;

  tba_touch_core #(.BOOT_CYCLES(20), .SCAN_CYCLES(400), .FADE_CYCLES(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .clk_scl(scl), .scl_in(scl), .sda_in(sda),
    .sda_drv(sda_drv), .reset_n_pin(reset_n_pin), .sensor_input(sensor_input),
    .led_pin_in(led_pins), .led_pin_drv(led_drv), .irq_n_pin_in(irq_line),
    .irq_n_pin_drv(irq_drv)
  );
  tba_host_model #(.FREE_TIME(20us)) host (
    .sda(sda), .scl(scl), .sda_pull(sda_pull), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .addr_ack(addr_ack)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_count(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      num_errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 1000 && irq_line !== lvl; i++) @(negedge clk_sys);
    cmp_byte("irq_line", {7'h00, lvl}, {7'h00, irq_line});
  endtask

  // High cycles of every led over one full pwm frame
  task automatic measure(output int cnt[NUM_CH]);
    cnt = '{default: 0};
    repeat (256) begin
      @(negedge clk_sys);
      foreach (cnt[c]) cnt[c] += int'(led_drv.o[c] === 1'b1);
    end
  endtask

  task automatic read_pair(input logic [7:0] b0, input logic [8:0] b1);
    exp_q.push_back({1'b1, b0});
    exp_q.push_back(b1);
    host.xfer(I2C_ADDR_DEF, 1'b1, 8'h00);
    cmp_byte("addr_ack", 8'h01, {7'h00, addr_ack});
  endtask

  always @(posedge rd_valid) begin
    nxt = exp_q.pop_front();
    if (nxt[8]) cmp_byte("read_byte", nxt[7:0], rd_byte);
  end

  initial begin
    #4ms;
    num_errors++;
    test_done();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int c1[NUM_CH];
    int c2[NUM_CH];
    logic [7:0] pat;
    logic [7:0] prev;
    prev = 8'h00;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    wait_irq(1'b1);
    for (int n = 0; n < 11; n++) begin
      seed = xs(seed);
      pat = (n < 8) ? 8'h01 << n : seed[7:0];
      if (pat == prev) pat = pat ^ 8'h01;
      sensor_input = pat;
      wait_irq(1'b0);
      // Level and duty are two flops behind the button state
      repeat (2) @(negedge clk_sys);
      measure(c1);
      read_pair(pat, 9'h000);
      wait_irq(1'b1);
      measure(c2);
      for (int c = 0; c < NUM_CH; c++) begin
        if (pat[c]) cmp_count("led_on", 510, c1[c] + c2[c]);
        else cmp_count("led_off", 0, c2[c]);
        if (prev[c] && !pat[c]) begin
          cmp_count("led_fade", 1, int'(c1[c] > 0 && c1[c] < 255));
        end
      end
      prev = pat;
    end
    host.xfer(I2C_ADDR_DEF, 1'b0, 8'h01);
    repeat (900) @(negedge clk_sys);
    cmp_byte("led_oe", 8'h00, led_drv.oe);
    gpi_val = seed[15:8];
    sensor_input = ~prev;
    repeat (900) @(negedge clk_sys);
    cmp_byte("irq_line", 8'h01, {7'h00, irq_line});
    read_pair(prev, {1'b1, gpi_val});
    host.xfer(I2C_ADDR_DEF, 1'b0, 8'h00);
    wait_irq(1'b0);
    read_pair(~prev, 9'h000);
    host.xfer(I2C_ADDR_DEF ^ 7'h01, 1'b1, 8'h00);
    cmp_byte("addr_ack", 8'h00, {7'h00, addr_ack});
    @(negedge clk_sys);
    reset_n_pin = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp_byte("irq_line", 8'h00, {7'h00, irq_line});
    cmp_byte("led_out", 8'h00, led_drv.o);
    wait_irq(1'b1);
    test_done();
  end
endmodule
